// *** design/bsfc_pkg.sv ***
// Behaviour
// - Enable high leaves shutdown and powers the internal regulator first.
// - During precharge connect precharge resistor and hold fault output high.
// - Output within 2 V of battery: open resistor, drive fault low.
// - Boost switching starts only after isolation switch is on.
// - Soft start ramps regulation reference up from zero.
// - Enable low shuts down immediately with isolation switch off.
// - Current-limit trip turns power switch off until next cycle.
// - Over-current beyond 16 ms at full duty latches shutdown.
// - Output 1.7 V below battery turns isolation off, latched shutdown.
// - Precharge not done after 32 ms latches shutdown, switch never on.
// - Overvoltage with no string current marks string open, drops it.
// - Shut down for open strings only when all six are excluded (open, over 17 V or grounded).
// - Overvoltage with current below target regulates at overvoltage level.
// - Sink over 17 V disables that sink and excludes it.
// - Grounded sink detected right after enable and excluded.
// - Six independent sink channels, each with own enable and exclusion.
// - All active sinks follow the dimming PWM input.
// - Feedback is lowest active sink voltage, regulated to 400 mV.
// - Battery undervoltage lockout disables; restart after hysteresis recovery.
package bsfc_pkg;
    localparam int unsigned N_STRINGS     = 6;
    localparam int unsigned CLK_HZ        = 200_000_000;
    localparam int unsigned SW_HZ         = 1_000_000;
    localparam int unsigned SW_DIV        = CLK_HZ / SW_HZ;
    localparam int unsigned SW_DIV_W      = 8;
    localparam int unsigned OC_TIME_MS    = 16;
    localparam int unsigned SC_DLY_MS     = 32;
    localparam int unsigned OC_SW_CYCLES  = OC_TIME_MS * (SW_HZ / 1000);
    localparam int unsigned SC_SW_CYCLES  = SC_DLY_MS * (SW_HZ / 1000);
    localparam int unsigned TMR_W         = 16;
    localparam int unsigned REF_W         = 8;
    localparam logic [7:0]  REF_FULL      = 8'hFF;
    localparam int unsigned SS_STEP_SW    = 4;
    localparam int unsigned LDO_SW_CYCLES = 8;
    localparam logic [SW_DIV_W-1:0] SW_DIV_LAST = SW_DIV_W'(SW_DIV - 1);

    typedef enum logic [2:0] {
        BSFC_OFF       = 3'b000,
        BSFC_LDO       = 3'b001,
        BSFC_PRECHARGE = 3'b011,
        BSFC_SOFTSTART = 3'b010,
        BSFC_RUN       = 3'b110,
        BSFC_LATCHED   = 3'b100
    } bsfc_state_t;
endpackage

// *** design/bsfc_sync.sv ***
`timescale 1ns/1ps
// Three-stage synchroniser; change accepted when stages two and three agree
module bsfc_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         mclk_i,
    input  wire logic         rstn_i,
    input  wire logic         ce_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s1  <= '0;
            s2  <= '0;
            s3  <= '0;
            q_o <= '0;
        end else if (ce_i) begin
            s1 <= d_i;
            s2 <= s1;
            s3 <= s2;
            for (int i = 0; i < W; i++) begin
                if (s2[i] == s3[i]) begin
                    q_o[i] <= s3[i];
                end
            end
        end
    end
endmodule // bsfc_sync

// *** design/bsfc_top.sv ***
`timescale 1ns/1ps
module bsfc_top
    import bsfc_pkg::*;
(
    input  wire logic                            mclk_i,
    input  wire logic                            rstn_i,
    input  wire logic                            ce_i,
    input  wire logic                            enable_i,
    input  wire logic                            dimming_pwm_input_i,
    input  wire logic                            uvlo_ok_i,
    input  wire logic                            near_batt_i,
    input  wire logic                            short_below_batt_i,
    input  wire logic                            ilim_trip_i,
    input  wire logic                            out_ovp_i,
    input  wire logic [bsfc_pkg::N_STRINGS-1:0] sink_no_current_i,
    input  wire logic [bsfc_pkg::N_STRINGS-1:0] sink_ovp_i,
    input  wire logic [bsfc_pkg::N_STRINGS-1:0] sink_grounded_i,
    input  wire logic                            below_target_i,
    output logic                                 ldo_on_o,
    output logic                                 precharge_on_o,
    output logic                                 fault_high_o,
    output logic                                 power_switch_o,
    output logic [bsfc_pkg::REF_W-1:0]          ref_level_o,
    output logic                                 clamp_at_ovp_o,
    output logic [bsfc_pkg::N_STRINGS-1:0]      sink_on_o,
    output logic [bsfc_pkg::N_STRINGS-1:0]      fb_select_o,
    output logic                                 latched_o
);
    import bsfc_pkg::*;

    localparam int unsigned NI = 6 + 3 * N_STRINGS;

    logic [NI-1:0]         raw_in;
    logic [NI-1:0]         syn_in;
    logic                  en_s;
    logic                  pwm_s;
    logic                  uvlo_s;
    logic                  near_s;
    logic                  short_s;
    logic                  ovp_s;
    logic [N_STRINGS-1:0]  nocur_s;
    logic [N_STRINGS-1:0]  sovp_s;
    logic [N_STRINGS-1:0]  gnd_s;
    bsfc_state_t           state;
    bsfc_state_t           next_state;
    logic [SW_DIV_W-1:0]   div_cnt;
    logic                  sw_tick;
    logic [TMR_W-1:0]      oc_tmr;
    logic [TMR_W-1:0]      sc_tmr;
    logic [TMR_W-1:0]      seq_tmr;
    logic                  oc_cycle;
    logic                  oc_fault;
    logic                  sc_fault;
    logic                  pre_timeout;
    logic                  all_open;
    logic [N_STRINGS-1:0]  excluded;
    logic                  active;

    assign raw_in = {sink_grounded_i, sink_ovp_i, sink_no_current_i, out_ovp_i,
                     short_below_batt_i, near_batt_i, uvlo_ok_i, dimming_pwm_input_i, enable_i};

    bsfc_sync #(
        .W (NI)
    ) u_sync (
        .mclk_i (mclk_i),
        .rstn_i (rstn_i),
        .ce_i   (ce_i),
        .d_i    (raw_in),
        .q_o    (syn_in)
    );

    assign en_s    = syn_in[0];
    assign pwm_s   = syn_in[1];
    assign uvlo_s  = syn_in[2];
    assign near_s  = syn_in[3];
    assign short_s = syn_in[4];
    assign ovp_s   = syn_in[5];
    assign nocur_s = syn_in[6 +: N_STRINGS];
    assign sovp_s  = syn_in[6 + N_STRINGS +: N_STRINGS];
    assign gnd_s   = syn_in[6 + 2 * N_STRINGS +: N_STRINGS];

    // Switching clock divider, one tick per switching cycle
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            div_cnt <= '0;
        end else if (ce_i) begin
            div_cnt <= (div_cnt == SW_DIV_LAST) ? '0 : div_cnt + 1'b1;
        end
    end
    assign sw_tick = (div_cnt == SW_DIV_LAST);

    // Per-cycle current limit; comparator comes from the same clock domain
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            oc_cycle <= 1'b0;
        end else if (ce_i) begin
            if (sw_tick) begin
                oc_cycle <= 1'b0;
            end else if (ilim_trip_i) begin
                oc_cycle <= 1'b1;
            end
        end
    end

    assign active = (state == BSFC_SOFTSTART) || (state == BSFC_RUN);

    // Switching only once isolation is on
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            power_switch_o <= 1'b0;
        end else if (ce_i) begin
            // Drops in the edge isolation opens, never a cycle after
            power_switch_o <= active && en_s && !oc_cycle && !ilim_trip_i
                              && ((next_state == BSFC_SOFTSTART) || (next_state == BSFC_RUN));
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            oc_tmr <= '0;
        end else if (ce_i) begin
            if (!active || !pwm_s) begin
                oc_tmr <= '0;
            end else if (sw_tick) begin
                oc_tmr <= oc_cycle ? oc_tmr + 1'b1 : '0;
            end
        end
    end
    assign oc_fault = (oc_tmr > TMR_W'(OC_SW_CYCLES));

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sc_tmr <= '0;
        end else if (ce_i) begin
            if (state != BSFC_PRECHARGE || near_s) begin
                sc_tmr <= '0;
            end else if (sw_tick) begin
                sc_tmr <= sc_tmr + 1'b1;
            end
        end
    end
    assign pre_timeout = (sc_tmr >= TMR_W'(SC_SW_CYCLES));

    assign sc_fault = active && short_s;
    assign all_open = &excluded;

    always_comb begin
        next_state = state;
        unique case (state)
            BSFC_OFF: begin
                if (en_s && uvlo_s) begin
                    next_state = BSFC_LDO;
                end
            end
            BSFC_LDO: begin
                if (sw_tick && seq_tmr >= TMR_W'(LDO_SW_CYCLES)) begin
                    next_state = BSFC_PRECHARGE;
                end
            end
            BSFC_PRECHARGE: begin
                if (near_s) begin
                    next_state = BSFC_SOFTSTART;
                end else if (pre_timeout) begin
                    next_state = BSFC_LATCHED;
                end
            end
            BSFC_SOFTSTART: begin
                if (sc_fault || oc_fault || all_open) begin
                    next_state = BSFC_LATCHED;
                end else if (ref_level_o == REF_FULL) begin
                    next_state = BSFC_RUN;
                end
            end
            BSFC_RUN: begin
                if (sc_fault || oc_fault || all_open) begin
                    next_state = BSFC_LATCHED;
                end
            end
            BSFC_LATCHED: begin
                next_state = BSFC_LATCHED;
            end
            default: begin
                next_state = BSFC_OFF;
            end
        endcase
        // Enable low or lockout shuts down at once
        if (!en_s || (!uvlo_s && state != BSFC_LATCHED)) begin
            next_state = BSFC_OFF;
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state <= BSFC_OFF;
        end else if (ce_i) begin
            state <= next_state;
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            seq_tmr <= '0;
        end else if (ce_i) begin
            if (state != next_state) begin
                seq_tmr <= '0;
            end else if (sw_tick) begin
                seq_tmr <= seq_tmr + 1'b1;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ref_level_o <= '0;
        end else if (ce_i) begin
            if (!active) begin
                ref_level_o <= '0;
            end else if (sw_tick && seq_tmr[1:0] == 2'(SS_STEP_SW - 1)
                         && ref_level_o != REF_FULL) begin
                ref_level_o <= ref_level_o + 1'b1;
            end
        end
    end

    for (genvar g = 0; g < N_STRINGS; g++) begin : g_str
        always_ff @(posedge mclk_i or negedge rstn_i) begin
            if (!rstn_i) begin
                excluded[g] <= 1'b0;
            end else if (ce_i) begin
                if (state == BSFC_OFF) begin
                    excluded[g] <= 1'b0;
                end else if (state == BSFC_LDO && gnd_s[g]) begin
                    excluded[g] <= 1'b1;
                end else if (active && sovp_s[g]) begin
                    excluded[g] <= 1'b1;
                end else if (active && ovp_s && nocur_s[g]) begin
                    excluded[g] <= 1'b1;
                end
            end
        end

        always_ff @(posedge mclk_i or negedge rstn_i) begin
            if (!rstn_i) begin
                sink_on_o[g] <= 1'b0;
            end else if (ce_i) begin
                sink_on_o[g] <= active && pwm_s && !excluded[g];
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            fb_select_o <= '0;
        end else if (ce_i) begin
            fb_select_o <= active ? ~excluded : '0;
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            clamp_at_ovp_o <= 1'b0;
        end else if (ce_i) begin
            clamp_at_ovp_o <= active && ovp_s && below_target_i && !(|(nocur_s & ~excluded));
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ldo_on_o       <= 1'b0;
            precharge_on_o <= 1'b0;
            fault_high_o   <= 1'b1;
            latched_o      <= 1'b0;
        end else if (ce_i) begin
            ldo_on_o       <= (next_state != BSFC_OFF) && (next_state != BSFC_LATCHED);
            precharge_on_o <= (next_state == BSFC_PRECHARGE);
            fault_high_o   <= !((next_state == BSFC_SOFTSTART) || (next_state == BSFC_RUN));
            latched_o      <= (next_state == BSFC_LATCHED);
        end
    end

    property p_en_off;
        @(posedge mclk_i) disable iff (!rstn_i)
        (ce_i && !en_s) |=> fault_high_o && !power_switch_o;
    endproperty
    a_en_off: assert property (p_en_off) else $error("isolation on without enable");

    property p_pre_fault;
        @(posedge mclk_i) disable iff (!rstn_i)
        precharge_on_o |-> fault_high_o;
    endproperty
    a_pre_fault: assert property (p_pre_fault) else $error("fault low in precharge");

    property p_iso_before_sw;
        @(posedge mclk_i) disable iff (!rstn_i)
        power_switch_o |-> $past(active);
    endproperty
    a_iso_before_sw: assert property (p_iso_before_sw) else $error("switch before isolation");
    property p_sw_iso;
        @(posedge mclk_i) disable iff (!rstn_i)
        power_switch_o |-> !fault_high_o;
    endproperty
    a_sw_iso: assert property (p_sw_iso) else $error("switch with isolation off");

    property p_ilim;
        @(posedge mclk_i) disable iff (!rstn_i)
        (ce_i && ilim_trip_i && !sw_tick) |=> !power_switch_o;
    endproperty
    a_ilim: assert property (p_ilim) else $error("switch on after limit trip");

    property p_oc_latch;
        @(posedge mclk_i) disable iff (!rstn_i)
        (ce_i && en_s && active && oc_fault) |=> ##1 latched_o || !en_s;
    endproperty
    a_oc_latch: assert property (p_oc_latch) else $error("over-current not latched");

    property p_sc_latch;
        @(posedge mclk_i) disable iff (!rstn_i)
        (ce_i && en_s && sc_fault) |=> (state == BSFC_LATCHED || state == BSFC_OFF);
    endproperty
    a_sc_latch: assert property (p_sc_latch) else $error("short not latched");

    property p_pre_to;
        @(posedge mclk_i) disable iff (!rstn_i)
        (ce_i && en_s && uvlo_s && state == BSFC_PRECHARGE && pre_timeout && !near_s)
            |=> state == BSFC_LATCHED;
    endproperty
    a_pre_to: assert property (p_pre_to) else $error("precharge timeout missed");

    property p_latch_hold;
        @(posedge mclk_i) disable iff (!rstn_i)
        (state == BSFC_LATCHED && en_s) |=> state == BSFC_LATCHED || !ce_i;
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latch released");

    property p_ramp;
        @(posedge mclk_i) disable iff (!rstn_i)
        $rose(active) |-> ref_level_o == '0;
    endproperty
    a_ramp: assert property (p_ramp) else $error("reference not from zero");

    property p_sink_pwm;
        @(posedge mclk_i) disable iff (!rstn_i)
        (ce_i && !pwm_s) |=> sink_on_o == '0;
    endproperty
    a_sink_pwm: assert property (p_sink_pwm) else $error("sink on while dimmed");

    c_run:   cover property (@(posedge mclk_i) state == BSFC_RUN);
    c_latch: cover property (@(posedge mclk_i) $rose(latched_o));
    c_excl:  cover property (@(posedge mclk_i) active && |excluded);
endmodule // bsfc_top

// *** bench/bsfc_stage_model.sv ***
`timescale 1ns/1ps
// Boost stage, isolation switch and strings as seen from the block
module bsfc_stage_model (
    input  wire logic                           mclk_i,
    input  wire logic                           precharge_on_i,
    input  wire logic                           fault_high_i,
    input  wire logic                           power_switch_i,
    input  wire logic                           short_mode_i,
    input  wire logic                           overload_i,
    input  wire logic                           ovp_force_i,
    input  wire logic [bsfc_pkg::N_STRINGS-1:0] open_mask_i,
    input  wire logic [bsfc_pkg::N_STRINGS-1:0] fb_select_i,
    output logic                                near_batt_o,
    output logic                                short_below_batt_o,
    output logic                                ilim_trip_o,
    output logic                                out_ovp_o,
    output logic [bsfc_pkg::N_STRINGS-1:0]      sink_no_current_o
);
    import bsfc_pkg::*;
    int unsigned charge = 0;
    // Resistor charging is slow; a shorted output never comes near
    always_ff @(posedge mclk_i) begin
        if (short_mode_i || (fault_high_i && !precharge_on_i)) begin
            charge <= 0;
        end else if (precharge_on_i && charge < 400) begin
            charge <= charge + 1;
        end
    end
    assign near_batt_o        = (charge >= 400);
    assign short_below_batt_o = short_mode_i & ~fault_high_i;
    // Overload: inductor hits the limit as soon as the switch closes
    assign ilim_trip_o        = overload_i & power_switch_i;
    assign sink_no_current_o  = open_mask_i;
    // An open string still in feedback pushes the output to its ceiling
    assign out_ovp_o          = ovp_force_i | (|(open_mask_i & fb_select_i));
endmodule // bsfc_stage_model

// *** bench/tb_backlight_startup_fault_control.sv ***
`timescale 1ns/1ps
module tb_backlight_startup_fault_control;
    import bsfc_pkg::*;
    typedef struct packed {
        logic                 pwm;
        logic [N_STRINGS-1:0] ovp;
        logic [N_STRINGS-1:0] sink;
        logic [N_STRINGS-1:0] fb;
    } bsfc_row_t;
    logic                 mclk = 1'b0;
    logic                 rstn = 1'b0;
    logic                 enable = 1'b0, pwm = 1'b0, below_target = 1'b0;
    logic                 ce = 1'b1, uvlo = 1'b1;
    logic                 short_mode = 1'b0, overload = 1'b0, ovp_force = 1'b0;
    logic [N_STRINGS-1:0] sink_ovp = '0, grounded = '0, open_mask = '0;
    logic                 near, short_below, ilim, out_ovp;
    logic [N_STRINGS-1:0] no_cur, sink_on, fb;
    logic                 ldo, pre, fault, sw, clamp, latched, prev_sw;
    logic [REF_W-1:0]     ref_lvl, prev_ref, ref_hold;
    int                   failures = 0, n_checks = 0, run = 0, rises = 0;
    bsfc_row_t            rows [5] = '{
        {1'b1, 6'h00, 6'h1F, 6'h1F}, {1'b0, 6'h00, 6'h00, 6'h1F},
        {1'b1, 6'h01, 6'h1E, 6'h1E}, {1'b0, 6'h01, 6'h00, 6'h1E},
        {1'b1, 6'h05, 6'h1A, 6'h1A}};

    always #2.5 mclk = ~mclk;

    bsfc_top i_bsfc_top (.mclk_i(mclk), .rstn_i(rstn), .ce_i(ce), .enable_i(enable),
        .dimming_pwm_input_i(pwm), .uvlo_ok_i(uvlo), .near_batt_i(near),
        .short_below_batt_i(short_below), .ilim_trip_i(ilim), .out_ovp_i(out_ovp),
        .sink_no_current_i(no_cur), .sink_ovp_i(sink_ovp), .sink_grounded_i(grounded),
        .below_target_i(below_target), .ldo_on_o(ldo), .precharge_on_o(pre),
        .fault_high_o(fault), .power_switch_o(sw), .ref_level_o(ref_lvl),
        .clamp_at_ovp_o(clamp), .sink_on_o(sink_on), .fb_select_o(fb), .latched_o(latched));

    bsfc_stage_model i_bsfc_stage_model (.mclk_i(mclk), .precharge_on_i(pre),
        .fault_high_i(fault), .power_switch_i(sw), .short_mode_i(short_mode),
        .overload_i(overload), .ovp_force_i(ovp_force), .open_mask_i(open_mask),
        .fb_select_i(fb), .near_batt_o(near), .short_below_batt_o(short_below),
        .ilim_trip_o(ilim), .out_ovp_o(out_ovp), .sink_no_current_o(no_cur));

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    function automatic logic pick(input int w);
        case (w)
            0: return ldo;
            1: return pre;
            2: return fault;
            default: return latched;
        endcase
    endfunction

    task automatic gap(input int n);
        repeat (n) @(negedge mclk);
    endtask

    // Bounded wait; running out ends the run
    task automatic wait_for(input int w, input logic v, input int bound);
        int i;
        @(negedge mclk);
        for (i = 0; i < bound && pick(w) !== v; i++) begin
            @(negedge mclk);
        end
        if (pick(w) !== v) begin
            failures++;
            $display("[FAIL] wait_%0d expected %b seen %b", w, v, pick(w));
            tally_and_finish();
        end
    endtask

    task automatic start();
        @(posedge mclk);
        enable <= 1'b1;
        wait_for(0, 1'b1, 20);
        chk("precharge_before_ldo", 8'h00, {7'h00, pre});
        wait_for(1, 1'b1, 3000);
        chk("fault_in_precharge", 8'h01, {7'h00, fault});
        wait_for(2, 1'b0, 3000);
        gap(2);
        chk("precharge_after_iso", 8'h00, {7'h00, pre});
    endtask

    task automatic disable_all();
        @(posedge mclk);
        enable <= 1'b0;
        gap(10);
        chk("ldo_after_disable", 8'h00, {7'h00, ldo});
        chk("fault_after_disable", 8'h01, {7'h00, fault});
    endtask

    // Watchers over the whole run
    always @(negedge mclk) begin
        if (rstn) begin
            chk("switch_with_iso_off", 8'h00, {7'h00, sw & fault});
            if (ref_lvl != prev_ref && ref_lvl != prev_ref + 8'h01 && ref_lvl != 8'h00) begin
                chk("ref_ramp_step", prev_ref + 8'h01, ref_lvl);
            end
            run = (overload && sw) ? run + 1 : 0;
            if (overload) begin
                chk("switch_after_trip", 8'h01, {7'h00, run <= 1});
            end
            if (overload && sw && !prev_sw) begin
                rises++;
            end
        end
        prev_ref = ref_lvl;
        prev_sw = sw;
    end

    initial begin
        repeat (3) @(posedge mclk);
        rstn <= 1'b1;
        @(negedge mclk);
        chk("reset_outputs", 8'h00, {ldo, pre, sw, clamp, latched, |sink_on, |fb, |ref_lvl});
        chk("reset_fault", 8'h01, {7'h00, fault});
        $display("test reset done");
        @(posedge mclk);
        grounded <= 6'h20;
        start();
        gap(4000);
        chk("ref_rising", 8'h01, {7'h00, ref_lvl > 8'h00 && ref_lvl < 8'h10});
        @(posedge mclk);
        ce <= 1'b0;
        gap(1);
        ref_hold = ref_lvl;
        gap(1000);
        chk("ref_frozen", ref_hold, ref_lvl);
        @(posedge mclk);
        ce <= 1'b1;
        $display("test startup done");
        foreach (rows[k]) begin
            @(posedge mclk);
            // dimming duty kept well above the achievable minimum
            pwm <= rows[k].pwm;
            sink_ovp <= rows[k].ovp;
            gap(8);
            chk("sink_on", {2'b00, rows[k].sink}, {2'b00, sink_on});
            chk("fb_select", {2'b00, rows[k].fb}, {2'b00, fb});
        end
        $display("test rows done");
        @(posedge mclk);
        rises = 0;
        overload <= 1'b1;
        gap(2000);
        @(posedge mclk);
        overload <= 1'b0;
        chk("switch_pulses", 8'h01, {7'h00, rises >= 8 && rises <= 11});
        $display("test current limit done");
        @(posedge mclk);
        below_target <= 1'b1;
        ovp_force <= 1'b1;
        gap(8);
        chk("clamp_at_ovp", 8'h01, {7'h00, clamp});
        chk("clamp_no_latch", 8'h00, {7'h00, latched});
        @(posedge mclk);
        ovp_force <= 1'b0;
        below_target <= 1'b0;
        open_mask <= 6'h02;
        gap(40);
        chk("open_dropped", 8'h18, {2'b00, fb});
        chk("open_no_latch", 8'h00, {7'h00, latched});
        @(posedge mclk);
        open_mask <= 6'h3F;
        wait_for(3, 1'b1, 100);
        chk("all_open_iso", 8'h01, {7'h00, fault});
        $display("test open strings done");
        @(posedge mclk);
        open_mask <= '0;
        sink_ovp <= '0;
        grounded <= '0;
        disable_all();
        start();
        chk("latch_cleared", 8'h00, {7'h00, latched});
        @(posedge mclk);
        uvlo <= 1'b0;
        wait_for(0, 1'b0, 20);
        chk("ldo_in_lockout", 8'h00, {7'h00, ldo});
        chk("iso_in_lockout", 8'h01, {7'h00, fault});
        @(posedge mclk);
        uvlo <= 1'b1;
        wait_for(0, 1'b1, 20);
        chk("ldo_after_lockout", 8'h01, {7'h00, ldo});
        wait_for(2, 1'b0, 3000);
        $display("test lockout done");
        @(posedge mclk);
        short_mode <= 1'b1;
        wait_for(3, 1'b1, 20);
        chk("short_iso_off", 8'h01, {7'h00, fault});
        $display("test short done");
        disable_all();
        @(posedge mclk);
        enable <= 1'b1;
        wait_for(1, 1'b1, 3000);
        gap(3000);
        chk("stuck_precharge_iso", 8'h01, {7'h00, fault});
        disable_all();
        gap(2);
        chk("precharge_at_disable", 8'h00, {7'h00, pre});
        $display("test disable in precharge done");
        tally_and_finish();
    end
endmodule // tb_backlight_startup_fault_control
